// file: adc_link_pkg.sv
// Shared constants and types for both ends of the converter link.
package adc_link_pkg;

  // ****************************************************************
  // Widths and clock
  // ****************************************************************
  localparam int CNT_W         = 16;
  localparam int RES_BITS_DEF  = 16;
  localparam int CLK_PERIOD_NS = 20;

  typedef logic [CNT_W-1:0] cnt_t;

  // ****************************************************************
  // Throughput and timing
  // ****************************************************************
  localparam int FAST_KSPS      = 1000;
  localparam int SLOW_KSPS      = 500;
  localparam int NS_PER_MS      = 1000000;
  localparam int CONV_TIME_NS   = 700;
  localparam int CAL_TIME_NS    = 2000;
  localparam int SCLK_MAX_MHZ   = 100;
  localparam int SCLK_HALF_DEF  = 4;
  localparam int RECAL_HOLD_DEF = 64;
  localparam int HOLD_MARGIN    = 8;
  localparam int WAKE_EDGES_DEF = 4;

  // Least time in ns rounded up to whole clock cycles.
  function automatic int ns_to_cycles(input int ns);
    return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  endfunction : ns_to_cycles

  // Least spacing of conversion starts for a sample rate in kSPS.
  function automatic int period_cycles(input int ksps);
    return ns_to_cycles(NS_PER_MS / ksps);
  endfunction : period_cycles

  localparam int CONV_CYCLES_DEF = ns_to_cycles(CONV_TIME_NS);
  localparam int CAL_CYCLES_DEF  = ns_to_cycles(CAL_TIME_NS);

  // ****************************************************************
  // State encodings
  // ****************************************************************
  typedef enum logic [3:0] {
    DEV_CAL     = 4'b0001,
    DEV_STANDBY = 4'b0010,
    DEV_CONVERT = 4'b0100,
    DEV_HOLD    = 4'b1000
  } dev_state_t;

  typedef enum logic [4:0] {
    H_WAKE   = 5'b00001,
    H_IDLE   = 5'b00010,
    H_STROBE = 5'b00100,
    H_SHIFT  = 5'b01000,
    H_SPACE  = 5'b10000
  } host_state_t;

endpackage : adc_link_pkg

// file: adc_link_if.sv
// Three-wire link between the host and the converter device.
`timescale 1ns/1ps
interface adc_link_if;
  logic conversion_start_strobe; // Host to device, starts a conversion.
  logic sclk;                    // Host to device, serial clock.
  logic serial_result_out;       // Device to host, result bits.

  modport device (
    input  conversion_start_strobe,
    input  sclk,
    output serial_result_out
  );

  modport host (
    output conversion_start_strobe,
    output sclk,
    input  serial_result_out
  );
endinterface : adc_link_if

// file: adc_device.sv
// Device end: calibration, conversion sequencing and result shifter.
`timescale 1ns/1ps
// Functional notes
// - Self-calibrate automatically after power-up
// - Recalibrate on host command any time (code: only as a strobe held high past a conversion begun in Standby)
// - Enter Standby once power-up finishes
// - Strobe rising edge starts a conversion
// - Host holds strobe high until done
// - Strobe low presents data, returns Standby
// - Host clocks data only during Standby
// - Conversion timed by internal clock only
// - Result belongs to same conversion
// - Result width 16, 14 or 12
// - Serial clock at most 100 MHz
// - Throughput limited to 1 Msps or 500k
// - Link is strobe, clock, data out
module adc_device #(
  parameter int RES_BITS    = adc_link_pkg::RES_BITS_DEF,   // 16, 14, 12.
  parameter bit FAST        = 1'b1,                         // Fast variant.
  parameter int CAL_CYCLES  = adc_link_pkg::CAL_CYCLES_DEF, // Calibration.
  parameter int CONV_CYCLES = adc_link_pkg::CONV_CYCLES_DEF,// Conversion.
  parameter int RECAL_HOLD  = adc_link_pkg::RECAL_HOLD_DEF  // Command hold.
) (
  input  wire logic                clk,          // Internal oscillator.
  input  wire logic                rstn,         // Power-up reset.
  adc_link_if.device               link,         // Three-wire link.
  input  wire logic [RES_BITS-1:0] sample_in,    // Analog input code.
  output logic                     calibrating,  // Calibration running.
  output logic                     converting,   // Conversion running.
  output logic                     standby,      // Acquiring input.
  output logic [RES_BITS-1:0]      result_word,  // Last result.
  output logic                     result_done   // Result ready pulse.
);
  import adc_link_pkg::*;

  // ****************************************************************
  // Local constants
  // ****************************************************************
  localparam int   IDX_W       = $clog2(RES_BITS);
  localparam int   MIN_PERIOD  = period_cycles(FAST ? FAST_KSPS : SLOW_KSPS);
  localparam cnt_t CAL_LAST    = cnt_t'(CAL_CYCLES - 1);
  localparam cnt_t CONV_LAST   = cnt_t'(CONV_CYCLES - 1);
  localparam cnt_t HOLD_LAST   = cnt_t'(RECAL_HOLD - 1);
  localparam cnt_t PERIOD_LAST = cnt_t'(MIN_PERIOD - 1);
  localparam logic [IDX_W-1:0] MSB_IDX = IDX_W'(RES_BITS - 1);
  localparam logic [RES_BITS-1:0] MSB_MASK = {1'b1, {(RES_BITS-1){1'b0}}};

  // ****************************************************************
  // Signals
  // ****************************************************************
  dev_state_t            state;
  cnt_t                  step_cnt;
  cnt_t                  period_cnt;
  cnt_t                  hold_cnt;
  logic                  strobe_meta;
  logic                  strobe_sync;
  logic                  strobe_prev;
  logic                  strobe_rise;
  logic                  start_ok;
  logic [RES_BITS-1:0]   held;
  logic [RES_BITS-1:0]   sample_meta;
  logic [RES_BITS-1:0]   sample_sync;
  logic [RES_BITS-1:0]   sar;
  logic [RES_BITS-1:0]   mask;
  logic [RES_BITS-1:0]   trial;
  logic                  link_clear;
  logic                  clear_meta;
  logic                  clear_sync;
  logic [IDX_W-1:0]      bit_sel;
  logic                  out_bit;

  // ****************************************************************
  // Strobe synchroniser
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      strobe_meta <= 1'b0;
      strobe_sync <= 1'b0;
      strobe_prev <= 1'b0;
      sample_meta <= '0;
      sample_sync <= '0;
    end else begin
      strobe_meta <= link.conversion_start_strobe;
      strobe_sync <= strobe_meta;
      strobe_prev <= strobe_sync;
      sample_meta <= sample_in;
      sample_sync <= sample_meta;
    end
  end

  assign strobe_rise = strobe_sync & ~strobe_prev;
  // Starts closer than the rated spacing are ignored.
  assign start_ok    = strobe_rise && (period_cnt == PERIOD_LAST);

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  // The sequence runs on the internal clock only; the serial clock has
  // no say in how long calibration or conversion takes.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state    <= DEV_CAL;
      step_cnt <= '0;
    end else begin
      unique case (state)
        DEV_CAL: begin
          if (step_cnt == CAL_LAST) begin
            state    <= DEV_STANDBY;
            step_cnt <= '0;
          end else begin
            step_cnt <= step_cnt + 1'b1;
          end
        end
        DEV_STANDBY: begin
          if (start_ok) begin
            state    <= DEV_CONVERT;
            step_cnt <= '0;
          end
        end
        DEV_CONVERT: begin
          if (step_cnt == CONV_LAST) begin
            state    <= DEV_HOLD;
            step_cnt <= '0;
          end else begin
            step_cnt <= step_cnt + 1'b1;
          end
        end
        DEV_HOLD: begin
          if (!strobe_sync) begin
            state <= DEV_STANDBY;
          end else if (hold_cnt == HOLD_LAST) begin
            // A strobe held high this long after the end of a conversion
            // is the recalibrate command.
            state    <= DEV_CAL;
            step_cnt <= '0;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Throughput spacing and command hold counters
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      period_cnt <= PERIOD_LAST;
    end else if (state == DEV_STANDBY && start_ok) begin
      period_cnt <= '0;
    end else if (period_cnt != PERIOD_LAST) begin
      period_cnt <= period_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      hold_cnt <= '0;
    end else if (state == DEV_HOLD && strobe_sync) begin
      hold_cnt <= hold_cnt + 1'b1;
    end else begin
      hold_cnt <= '0;
    end
  end

  // ****************************************************************
  // Successive approximation core
  // ****************************************************************
  assign trial = sar | mask;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      held <= '0;
      sar  <= '0;
      mask <= '0;
    end else if (state == DEV_STANDBY && start_ok) begin
      held <= sample_sync;
      sar  <= '0;
      mask <= MSB_MASK;
    end else if (state == DEV_CONVERT && mask != '0) begin
      if (trial <= held) begin
        sar <= trial;
      end
      mask <= mask >> 1;
    end
  end

  // The word is taken from this very conversion, so a read after the
  // strobe falls returns the sample just taken.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      result_word <= '0;
      result_done <= 1'b0;
    end else if (state == DEV_CONVERT && step_cnt == CONV_LAST) begin
      result_word <= sar;
      result_done <= 1'b1;
    end else begin
      result_done <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      link_clear <= 1'b1;
    end else begin
      link_clear <= (state == DEV_CAL);
    end
  end

  assign calibrating = (state == DEV_CAL);
  assign converting  = (state == DEV_CONVERT);
  assign standby     = (state == DEV_STANDBY);

  // ****************************************************************
  // Link shifter on the serial clock
  // ****************************************************************
  // A high strobe marks the gap between reads, so the bit pointer is set
  // back to the first bit before every read, whatever came before. The
  // calibration clear only gives the data pin a known level at power-up.
  always_ff @(posedge link.sclk or posedge link.conversion_start_strobe) begin
    if (link.conversion_start_strobe) begin
      clear_meta <= 1'b0;
      clear_sync <= 1'b0;
      bit_sel    <= MSB_IDX;
    end else begin
      clear_meta <= link_clear;
      clear_sync <= clear_meta;
      if (clear_sync) begin
        bit_sel <= MSB_IDX;
      end else begin
        bit_sel <= (bit_sel == '0) ? MSB_IDX : bit_sel - 1'b1;
      end
    end
  end

  // The result word changes only at the end of a conversion, when the
  // host keeps the serial clock still, so it is stable at every edge.
  always_ff @(posedge link.sclk) begin
    if (clear_sync) begin
      out_bit <= 1'b0;
    end else begin
      out_bit <= result_word[bit_sel];
    end
  end

  assign link.serial_result_out = out_bit;

endmodule : adc_device

// file: adc_host.sv
// Host end: strobe timing, serial clock divider and result capture.
`timescale 1ns/1ps
module adc_host #(
  parameter int RES_BITS    = adc_link_pkg::RES_BITS_DEF,   // 16, 14, 12.
  parameter bit FAST        = 1'b1,                         // Fast variant.
  parameter int SCLK_HALF   = adc_link_pkg::SCLK_HALF_DEF,  // Half period.
  parameter int STROBE_HOLD = adc_link_pkg::CONV_CYCLES_DEF
                              + adc_link_pkg::HOLD_MARGIN,  // Strobe high.
  parameter int RECAL_HOLD  = adc_link_pkg::RECAL_HOLD_DEF
                              + adc_link_pkg::HOLD_MARGIN,  // Extra hold.
  parameter int CAL_WAIT    = adc_link_pkg::CAL_CYCLES_DEF
                              + adc_link_pkg::HOLD_MARGIN,  // Cal wait.
  parameter int WAKE_EDGES  = adc_link_pkg::WAKE_EDGES_DEF  // Wake clocks.
) (
  input  wire logic                clk,          // System clock.
  input  wire logic                rstn,         // Synchronous reset.
  adc_link_if.host                 link,         // Three-wire link.
  input  wire logic                start_req,    // Request a conversion.
  input  wire logic                recal_req,    // Request recalibration.
  output logic                     ready,        // Idle, takes requests.
  output logic [RES_BITS-1:0]      result_word,  // Captured result.
  output logic                     result_valid  // Result pulse.
);
  import adc_link_pkg::*;

  // ****************************************************************
  // Local constants
  // ****************************************************************
  localparam int   MIN_PERIOD = period_cycles(FAST ? FAST_KSPS : SLOW_KSPS)
                                + HOLD_MARGIN;
  localparam cnt_t HALF_LAST  = cnt_t'(SCLK_HALF - 1);
  localparam cnt_t HOLD_LAST  = cnt_t'(STROBE_HOLD - 1);
  localparam cnt_t RHOLD_LAST = cnt_t'(STROBE_HOLD + RECAL_HOLD - 1);
  localparam cnt_t WAKE_LAST  = cnt_t'(WAKE_EDGES - 1);
  localparam cnt_t BITS_LAST  = cnt_t'(RES_BITS - 1);

  // ****************************************************************
  // Signals
  // ****************************************************************
  host_state_t         state;
  cnt_t                wait_cnt;
  cnt_t                space_target;
  cnt_t                div;
  cnt_t                edge_cnt;
  logic                sclk;
  logic                strobe;
  logic                recal_mode;
  logic                sclk_run;
  logic                fall;
  logic                din_meta;
  logic                din_sync;
  logic [RES_BITS-1:0] shreg;

  assign link.sclk                    = sclk;
  assign link.conversion_start_strobe = strobe;
  assign ready                        = (state == H_IDLE);

  // ****************************************************************
  // Serial clock divider
  // ****************************************************************
  // Runs only while waking the device or reading; a half period of at
  // least one cycle keeps the clock well under 100 MHz.
  assign sclk_run = (state == H_WAKE) || (state == H_SHIFT);
  assign fall     = sclk_run && sclk && (div == HALF_LAST);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      div  <= '0;
      sclk <= 1'b0;
    end else if (!sclk_run) begin
      div  <= '0;
      sclk <= 1'b0;
    end else if (div == HALF_LAST) begin
      div  <= '0;
      sclk <= ~sclk;
    end else begin
      div <= div + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      din_meta <= 1'b0;
      din_sync <= 1'b0;
    end else begin
      din_meta <= link.serial_result_out;
      din_sync <= din_meta;
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state        <= H_WAKE;
      wait_cnt     <= '0;
      space_target <= '0;
      edge_cnt     <= '0;
      strobe       <= 1'b0;
      recal_mode   <= 1'b0;
    end else begin
      unique case (state)
        H_WAKE: begin
          if (fall) begin
            edge_cnt <= edge_cnt + 1'b1;
            if (edge_cnt == WAKE_LAST) begin
              state        <= H_SPACE;
              wait_cnt     <= '0;
              space_target <= cnt_t'(CAL_WAIT);
            end
          end
        end
        H_IDLE: begin
          wait_cnt <= '0;
          edge_cnt <= '0;
          if (recal_req || start_req) begin
            state      <= H_STROBE;
            strobe     <= 1'b1;
            recal_mode <= recal_req;
          end
        end
        H_STROBE: begin
          wait_cnt <= wait_cnt + 1'b1;
          if (wait_cnt == (recal_mode ? RHOLD_LAST : HOLD_LAST)) begin
            strobe <= 1'b0;
            if (recal_mode) begin
              state        <= H_SPACE;
              space_target <= cnt_t'(STROBE_HOLD + RECAL_HOLD + CAL_WAIT);
            end else begin
              state        <= H_SHIFT;
              space_target <= cnt_t'(MIN_PERIOD);
            end
          end
        end
        H_SHIFT: begin
          wait_cnt <= wait_cnt + 1'b1;
          if (fall) begin
            edge_cnt <= edge_cnt + 1'b1;
            if (edge_cnt == BITS_LAST) begin
              state <= H_SPACE;
            end
          end
        end
        H_SPACE: begin
          wait_cnt <= wait_cnt + 1'b1;
          if (wait_cnt >= space_target) begin
            state <= H_IDLE;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Result capture, most significant bit first
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      shreg        <= '0;
      result_word  <= '0;
      result_valid <= 1'b0;
    end else if (state == H_SHIFT && fall) begin
      shreg <= {shreg[RES_BITS-2:0], din_sync};
      if (edge_cnt == BITS_LAST) begin
        result_word  <= {shreg[RES_BITS-2:0], din_sync};
        result_valid <= 1'b1;
      end else begin
        result_valid <= 1'b0;
      end
    end else begin
      result_valid <= 1'b0;
    end
  end

endmodule : adc_host

// file: adc_link_monitor.sv
// Concurrent checks on the converter link and the status lines of both ends.
`timescale 1ns/1ps
module adc_link_monitor #(
  parameter int CONV_CYCLES = 20, // Conversion length in device clocks.
  parameter int CAL_CYCLES  = 30, // Calibration length in device clocks.
  parameter int RES_BITS    = 16  // Result word width.
) (
  input wire logic dev_clk,                 // Device clock.
  input wire logic host_clk,                // Host clock.
  input wire logic rstn,                    // Shared reset, active low.
  input wire logic conversion_start_strobe, // Link strobe.
  input wire logic sclk,                    // Link serial clock.
  input wire logic serial_result_out,       // Link data.
  input wire logic calibrating,             // Device calibrating.
  input wire logic converting,              // Device converting.
  input wire logic standby,                 // Device in Standby.
  input wire logic result_done,             // Device result pulse.
  input wire logic result_valid             // Host result pulse.
);
  localparam int CONV_LO = CONV_CYCLES - 2;
  localparam int CONV_HI = CONV_CYCLES + 2;
  localparam int CAL_LO  = CAL_CYCLES - 2;
  localparam int CAL_HI  = CAL_CYCLES + 4;

  logic       sclk_q;
  logic [7:0] fall_cnt;

  always_ff @(posedge host_clk) begin
    sclk_q <= sclk;
  end

  // Counts falling serial clock edges since the strobe was last high.
  always_ff @(posedge host_clk) begin
    if (!rstn || conversion_start_strobe) begin
      fall_cnt <= 8'h00;
    end else if (sclk_q && !sclk) begin
      fall_cnt <= fall_cnt + 8'h01;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_strobe_starts_conv: assert property (@(posedge dev_clk) disable iff (!rstn)
    $rose(conversion_start_strobe) && standby |-> ##[1:5] converting)
    else $error("strobe rise in standby did not start a conversion");
  a_conv_then_done: assert property (@(posedge dev_clk) disable iff (!rstn)
    $rose(converting) |-> ##[CONV_LO:CONV_HI] result_done)
    else $error("conversion did not end on its own count");
  a_no_sclk_conv: assert property (@(posedge dev_clk) disable iff (!rstn)
    converting |-> !sclk)
    else $error("serial clock high during a conversion");
  a_sclk_strobe_low: assert property (@(posedge host_clk) disable iff (!rstn)
    sclk |-> !conversion_start_strobe)
    else $error("serial clock high while strobe high");
  a_strobe_held_conv: assert property (@(posedge dev_clk) disable iff (!rstn)
    converting |-> conversion_start_strobe)
    else $error("strobe low during a conversion");
  a_powerup_cal: assert property (@(posedge dev_clk) disable iff (!rstn)
    $rose(rstn) |-> calibrating ##[CAL_LO:CAL_HI] standby)
    else $error("power-up calibration missing or wrong length");
  a_cal_to_standby: assert property (@(posedge dev_clk) disable iff (!rstn)
    $fell(calibrating) |-> standby)
    else $error("calibration did not end in standby");
  a_sdo_on_rise: assert property (@(posedge host_clk) disable iff (!rstn)
    $changed(serial_result_out) |-> $rose(sclk))
    else $error("data changed away from a rising serial clock");
  a_word_bit_count: assert property (@(posedge host_clk) disable iff (!rstn)
    $rose(result_valid) |-> ##1 fall_cnt == 8'(RES_BITS))
    else $error("result word not made of one clock per bit");

  c_conv: cover property (@(posedge dev_clk) disable iff (!rstn)
    $rose(converting));
  c_recal: cover property (@(posedge dev_clk) disable iff (!rstn)
    $rose(calibrating));
  c_read: cover property (@(posedge host_clk) disable iff (!rstn)
    result_valid);
endmodule : adc_link_monitor

// file: tb_top.sv
// Self-checking bench joining the host and device ends over the link.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin \
  miscompares++; $display("BAD %s exp=%0h got=%0h", nm, ex, got); end end
module tb_top;
  import adc_link_pkg::*;
  localparam int RES   = 16;
  localparam int CONV  = 20;
  localparam int CAL   = 30;
  localparam int LIMIT = 12000;

  logic           host_clk, dev_clk, rstn, start_req, recal_req;
  logic           calibrating, converting, standby, result_done;
  logic           ready, result_valid;
  logic [RES-1:0] sample_in, dev_word, host_word, wire_word, expect_w;
  logic [RES-1:0] corners [4] = '{16'h0000, 16'hffff, 16'h8000, 16'h5aa5};
  int             miscompares, num_checks, cycles, seed, i;

  adc_link_if link ();

  adc_device #(.RES_BITS(RES), .CAL_CYCLES(CAL),
    .CONV_CYCLES(CONV), .RECAL_HOLD(16)) adc_device_inst (
    .clk(dev_clk), .rstn(rstn), .link(link), .sample_in(sample_in),
    .calibrating(calibrating), .converting(converting), .standby(standby),
    .result_word(dev_word), .result_done(result_done));

  adc_host #(.RES_BITS(RES), .STROBE_HOLD(44), .RECAL_HOLD(40),
    .CAL_WAIT(60)) adc_host_inst (
    .clk(host_clk), .rstn(rstn), .link(link), .start_req(start_req),
    .recal_req(recal_req), .ready(ready), .result_word(host_word),
    .result_valid(result_valid));

  adc_link_monitor #(.CONV_CYCLES(CONV), .CAL_CYCLES(CAL), .RES_BITS(RES))
    adc_link_monitor_inst (
    .dev_clk(dev_clk), .host_clk(host_clk), .rstn(rstn),
    .conversion_start_strobe(link.conversion_start_strobe),
    .sclk(link.sclk), .serial_result_out(link.serial_result_out),
    .calibrating(calibrating), .converting(converting), .standby(standby),
    .result_done(result_done), .result_valid(result_valid));

  always #10 host_clk = ~host_clk;
  always #16 dev_clk = ~dev_clk;

  // Keeps the last word seen on the wire, sampled as the host does.
  always @(negedge link.sclk) begin
    wire_word <= {wire_word[RES-2:0], link.serial_result_out};
  end

  always @(posedge host_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      miscompares++;
      test_done();
    end
  end

  // The word the host must read back for a given input code.
  function automatic logic [RES-1:0] expect_code(input logic [RES-1:0] v);
    return v;
  endfunction : expect_code

  task automatic wait_ready();
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 2000) begin
      @(negedge host_clk);
      n++;
    end
    `CHK("ready", 1'b1, ready)
  endtask : wait_ready

  task automatic convert(input logic [RES-1:0] v);
    int n;
    wait_ready();
    sample_in = v;
    start_req = 1'b1;
    @(negedge host_clk);
    start_req = 1'b0;
    n = 0;
    while (result_valid !== 1'b1 && n < 400) begin
      @(negedge host_clk);
      n++;
    end
    `CHK("result_valid", 1'b1, result_valid)
    expect_w = expect_code(v);
    `CHK("host_word", expect_w, host_word)
    `CHK("dev_word", expect_w, dev_word)
    `CHK("wire_word", expect_w, wire_word)
    wait_ready();
    `CHK("standby", 1'b1, standby)
    `CHK("sclk_idle", 1'b0, link.sclk)
  endtask : convert

  task automatic recalibrate();
    int n;
    wait_ready();
    recal_req = 1'b1;
    @(negedge host_clk);
    recal_req = 1'b0;
    n = 0;
    while (calibrating !== 1'b1 && n < 300) begin
      @(negedge host_clk);
      n++;
    end
    `CHK("calibrating", 1'b1, calibrating)
  endtask : recalibrate

  task automatic test_done();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    host_clk  = 1'b0;
    dev_clk   = 1'b0;
    rstn      = 1'b0;
    start_req = 1'b0;
    recal_req = 1'b0;
    sample_in = '0;
    seed      = 97913;
    repeat (12) @(negedge host_clk);
    rstn = 1'b1;
    @(negedge host_clk);
    `CHK("cal_at_power_up", 1'b1, calibrating)
    wait_ready();
    `CHK("standby_after_cal", 1'b1, standby)
    for (i = 0; i < 4; i++) begin
      convert(corners[i]);
    end
    for (i = 0; i < 12; i++) begin
      convert(RES'($random(seed)));
    end
    recalibrate();
    convert(RES'($random(seed)));
    convert(corners[3]);
    test_done();
  end
endmodule : tb_top
